// ---- hw/mcc_map.svh ----
`ifndef MCC_MAP_SVH
`define MCC_MAP_SVH

// register addresses on the internal register port
`define MCC_ADDR_CFG_ONE   8'h18
`define MCC_ADDR_CFG_TWO   8'h19
`define MCC_CFG_RESET      8'h00
`define MCC_RD_UNMAPPED    8'h00

// control_config_one field positions
`define MCC_ONE_MONITOR    0
`define MCC_ONE_MUX_LO     1
`define MCC_ONE_MUX_HI     2
`define MCC_ONE_PIN9_ANA   3
`define MCC_ONE_RSVD       4
`define MCC_ONE_INT_OFF    5
`define MCC_ONE_INT_POL    6
`define MCC_ONE_STANDBY    7

// control_config_two field positions
`define MCC_TWO_CHAN_LO    0
`define MCC_TWO_CHAN_HI    2
`define MCC_TWO_SINGLE     4
`define MCC_TWO_AVG_OFF    5
`define MCC_TWO_TMO_EN     6
`define MCC_TWO_SW_RESET   7

// averaging depths
`define MCC_AVG_DEFAULT    5'h10
`define MCC_AVG_NONE       5'h01

// serial clock low timeout
`define MCC_TMO_MS         25
`define MCC_CLK_KHZ        25000
`define MCC_TMO_CYCLES     (`MCC_TMO_MS * `MCC_CLK_KHZ)
`define MCC_TMO_WIDTH      20

`endif

// ---- hw/mcc_pkg.sv ----
`default_nettype none

package mcc_pkg;

  // analog mux of the shared pins
  typedef enum logic [1:0] {
    MCC_MUX_AIN_PAIR = 2'b00,
    MCC_MUX_UNDEF_A  = 2'b01,
    MCC_MUX_EXT_DIODE = 2'b10,
    MCC_MUX_UNDEF_B  = 2'b11
  } mcc_mux_type;

  // resolved single-channel conversion source
  typedef enum logic [2:0] {
    MCC_SRC_SUPPLY   = 3'b000,
    MCC_SRC_INT_TEMP = 3'b001,
    MCC_SRC_EXT_TEMP = 3'b010,
    MCC_SRC_AIN_ONE  = 3'b011,
    MCC_SRC_AIN_TWO  = 3'b100,
    MCC_SRC_AIN_THREE = 3'b101,
    MCC_SRC_AIN_FOUR = 3'b110,
    MCC_SRC_NONE     = 3'b111
  } mcc_src_type;

endpackage : mcc_pkg

`default_nettype wire

// ---- hw/mcc_scl_timeout.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.svh"

module mcc_scl_timeout #(
  parameter int unsigned LIMIT = `MCC_TMO_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic enable,
  input  wire logic sclLow,
  output logic      expired_q
);

  localparam logic [`MCC_TMO_WIDTH-1:0] LIMIT_W = LIMIT[`MCC_TMO_WIDTH-1:0];

  logic [`MCC_TMO_WIDTH-1:0] lowCount_q;

  // count how long the serial clock stays low
  always_ff @(posedge core_clk) begin
    if (!nrst || !enable || !sclLow) begin
      lowCount_q <= '0;
    end else if (lowCount_q != LIMIT_W) begin
      lowCount_q <= lowCount_q + 1'b1;
    end
  end

  // flag holds until the clock goes high again
  always_ff @(posedge core_clk) begin
    if (!nrst || !enable || !sclLow) begin
      expired_q <= 1'b0;
    end else if (lowCount_q == LIMIT_W - 1'b1) begin
      expired_q <= 1'b1;
    end
  end

endmodule : mcc_scl_timeout
`default_nettype wire

// ---- hw/mcc_regs.sv ----
// How it works
// R1 - monitoring runs only while the enable bit is 1, starting in round robin after power-up.
// R2 - mux field 00 routes the shared pins to analog inputs one and two, 10 to the thermal diode.
// R3 - the pin-function bit picks load strobe (0) or analog input three (1) and masks the update-source bit.
// R4 - the host writes 0 to reserved bit four of the first register.
// R5 - the interrupt output is enabled when its disable bit is 0.
// R6 - the polarity bit makes the interrupt active low (0) or active high (1).
// R7 - the standby bit powers down ADC and DACs while register access keeps working.
// R8 - the channel field picks supply, internal temp, ext temp or inputs one to four; 110 and 111 are reserved.
// R9 - channel code 010 resolves to external temperature or input one by the mux field.
// R10 - the cycle-type bit picks round robin (0) or single channel (1).
// R11 - measurements average over 16 conversions unless the averaging-disable bit is 1.
// R12 - with timeout enabled a serial clock held low for 25 ms releases the data line.
// R13 - writing 1 to the software reset bit returns all registers and DAC outputs to defaults.
// R14 - both registers are 8 bits, read/write, and zero after power-up.
// R15 - update-source 0 lets the load-strobe pin update DACs, 1 hands it to the configuration registers.
// R16 - a disabled interrupt output sits at the inactive level of the chosen polarity.
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.svh"

module mcc_regs
  import mcc_pkg::*;
#(
  parameter int unsigned TMO_CYCLES = `MCC_TMO_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrEn,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData_q,
  input  wire logic        alarmEvent,
  input  wire logic        updateSourceBit,
  input  wire logic        dacLoadStrobePin,
  input  wire logic        sclPin,
  output logic             intOut_q,
  output logic             monitorRun_q,
  output logic             singleChannel_q,
  output mcc_mux_type      analogMux_q,
  output logic             pin9Analog_q,
  output mcc_src_type      convSource_q,
  output logic      [4:0]  averageDepth_q,
  output logic             standby_q,
  output logic             pinControlsUpdate_q,
  output logic             dacPinLoad_q,
  output logic             swResetPulse_q,
  output logic             sdaRelease_q
);

  logic [7:0] cfgOne_q;
  logic [7:0] cfgTwo_q;
  logic       swReset;
  logic       wrOne;
  logic       wrTwo;
  logic [1:0] ldacSync_q;
  logic       ldacPrev_q;
  logic [1:0] sclSync_q;
  logic       tmoExpired_q;
  mcc_src_type srcNext;

  assign wrOne   = regWrEn && (regAddr == `MCC_ADDR_CFG_ONE);
  assign wrTwo   = regWrEn && (regAddr == `MCC_ADDR_CFG_TWO);
  // R13 soft reset request
  assign swReset = wrTwo && regWrData[`MCC_TWO_SW_RESET];

  // R14 first register, cleared by reset
  // R13 soft reset clears it too
  always_ff @(posedge core_clk) begin
    if (!nrst || swReset) begin
      cfgOne_q <= `MCC_CFG_RESET;
    end else if (wrOne) begin
      cfgOne_q <= regWrData;
    end
  end

  // R14 second register; the reset bit never stays set
  always_ff @(posedge core_clk) begin
    if (!nrst || swReset) begin
      cfgTwo_q <= `MCC_CFG_RESET;
    end else if (wrTwo) begin
      cfgTwo_q <= regWrData;
    end
  end

  // read data appears the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      regRdData_q <= `MCC_RD_UNMAPPED;
    end else if (regRdEn) begin
      unique case (regAddr)
        `MCC_ADDR_CFG_ONE: regRdData_q <= cfgOne_q;
        `MCC_ADDR_CFG_TWO: regRdData_q <= cfgTwo_q;
        default:           regRdData_q <= `MCC_RD_UNMAPPED;
      endcase
    end
  end

  // R8 R9 resolve the channel code to a source
  always_comb begin
    srcNext = MCC_SRC_NONE;
    unique case (cfgTwo_q[`MCC_TWO_CHAN_HI:`MCC_TWO_CHAN_LO])
      3'h0: srcNext = MCC_SRC_SUPPLY;
      3'h1: srcNext = MCC_SRC_INT_TEMP;
      3'h2: srcNext = (cfgOne_q[`MCC_ONE_MUX_HI:`MCC_ONE_MUX_LO] == MCC_MUX_EXT_DIODE)
                      ? MCC_SRC_EXT_TEMP : MCC_SRC_AIN_ONE;
      3'h3: srcNext = MCC_SRC_AIN_TWO;
      3'h4: srcNext = MCC_SRC_AIN_THREE;
      3'h5: srcNext = MCC_SRC_AIN_FOUR;
      default: srcNext = MCC_SRC_NONE;
    endcase
  end

  // mode outputs for the conversion datapath
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      monitorRun_q    <= 1'b0;
      singleChannel_q <= 1'b0;
      analogMux_q     <= MCC_MUX_AIN_PAIR;
      pin9Analog_q    <= 1'b0;
      convSource_q    <= MCC_SRC_SUPPLY;
      averageDepth_q  <= `MCC_AVG_DEFAULT;
      standby_q       <= 1'b0;
    end else begin
      // R1 R7 monitoring gated by enable and standby
      monitorRun_q    <= cfgOne_q[`MCC_ONE_MONITOR] && !cfgOne_q[`MCC_ONE_STANDBY];
      // R10 cycle type
      singleChannel_q <= cfgTwo_q[`MCC_TWO_SINGLE];
      // R2 shared pin mux
      analogMux_q     <= mcc_mux_type'(cfgOne_q[`MCC_ONE_MUX_HI:`MCC_ONE_MUX_LO]);
      // R3 pin nine function
      pin9Analog_q    <= cfgOne_q[`MCC_ONE_PIN9_ANA];
      convSource_q    <= srcNext;
      // R11 averaging depth
      averageDepth_q  <= cfgTwo_q[`MCC_TWO_AVG_OFF] ? `MCC_AVG_NONE : `MCC_AVG_DEFAULT;
      // R7 standby powers down analog parts
      standby_q       <= cfgOne_q[`MCC_ONE_STANDBY];
    end
  end

  // R5 R6 R16 interrupt pin level
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      intOut_q <= 1'b1;
    end else if (!cfgOne_q[`MCC_ONE_INT_OFF] && alarmEvent) begin
      intOut_q <= cfgOne_q[`MCC_ONE_INT_POL];
    end else begin
      intOut_q <= !cfgOne_q[`MCC_ONE_INT_POL];
    end
  end

  // load strobe pin synchroniser and edge memory
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      ldacSync_q <= 2'b11;
      ldacPrev_q <= 1'b1;
    end else begin
      ldacSync_q <= {ldacSync_q[0], dacLoadStrobePin};
      ldacPrev_q <= ldacSync_q[1];
    end
  end

  // R3 R15 update source and pin load pulse
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pinControlsUpdate_q <= 1'b1;
      dacPinLoad_q        <= 1'b0;
    end else begin
      pinControlsUpdate_q <= !cfgOne_q[`MCC_ONE_PIN9_ANA] && !updateSourceBit;
      dacPinLoad_q        <= pinControlsUpdate_q && ldacPrev_q && !ldacSync_q[1];
    end
  end

  // R13 reset pulse to DAC outputs
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      swResetPulse_q <= 1'b0;
    end else begin
      swResetPulse_q <= swReset;
    end
  end

  // serial clock synchroniser
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sclSync_q <= 2'b11;
    end else begin
      sclSync_q <= {sclSync_q[0], sclPin};
    end
  end

  // R12 low-time watchdog on the serial clock
  mcc_scl_timeout #(
    .LIMIT (TMO_CYCLES)
  ) u_tmo (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .enable    (cfgTwo_q[`MCC_TWO_TMO_EN]),
    .sclLow    (!sclSync_q[1]),
    .expired_q (tmoExpired_q)
  );

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sdaRelease_q <= 1'b0;
    end else begin
      sdaRelease_q <= tmoExpired_q;
    end
  end

  sequence SEQ_WR_ONE(logic [7:0] v);
    wrOne && !swReset && (regWrData == v);
  endsequence

  sequence SEQ_RD_ONE;
    regRdEn && !regWrEn && (regAddr == `MCC_ADDR_CFG_ONE);
  endsequence

  AST_PWRUP_ZERO: assert property (@(posedge core_clk) // R14
    !$past(nrst) |-> cfgOne_q == `MCC_CFG_RESET && cfgTwo_q == `MCC_CFG_RESET)
    else $error("config registers not zero after reset");
  AST_SWRST_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst) // R13
    swReset |=> cfgOne_q == `MCC_CFG_RESET && cfgTwo_q == `MCC_CFG_RESET && swResetPulse_q)
    else $error("soft reset did not clear registers");
  // the written byte comes back on a read four cycles later
  AST_READBACK: assert property (@(posedge core_clk) disable iff (!nrst) // R14
    SEQ_WR_ONE(regWrData) ##1 !regWrEn [*3] ##1 SEQ_RD_ONE |=> regRdData_q == $past(regWrData, 5))
    else $error("readback mismatch");
  AST_MONITOR: assert property (@(posedge core_clk) disable iff (!nrst) // R1
    monitorRun_q |-> $past(cfgOne_q[`MCC_ONE_MONITOR]) && !standby_q)
    else $error("monitoring without enable");
  AST_STANDBY: assert property (@(posedge core_clk) disable iff (!nrst) // R7
    SEQ_WR_ONE(8'h81) |=> ##1 standby_q && !monitorRun_q)
    else $error("standby did not stop monitoring");
  AST_INT_OFF: assert property (@(posedge core_clk) disable iff (!nrst) // R16
    $past(cfgOne_q[`MCC_ONE_INT_OFF]) |-> intOut_q == !$past(cfgOne_q[`MCC_ONE_INT_POL]))
    else $error("disabled interrupt not inactive");
  AST_INT_ACTIVE: assert property (@(posedge core_clk) disable iff (!nrst) // R6
    (!cfgOne_q[`MCC_ONE_INT_OFF] && alarmEvent) |=> intOut_q == $past(cfgOne_q[`MCC_ONE_INT_POL]))
    else $error("interrupt polarity wrong");
  AST_CHAN_010: assert property (@(posedge core_clk) disable iff (!nrst) // R9
    (cfgTwo_q[`MCC_TWO_CHAN_HI:`MCC_TWO_CHAN_LO] == 3'h2
     && cfgOne_q[`MCC_ONE_MUX_HI:`MCC_ONE_MUX_LO] == MCC_MUX_EXT_DIODE)
    |=> convSource_q == MCC_SRC_EXT_TEMP)
    else $error("channel 010 mux wrong");
  AST_AVG: assert property (@(posedge core_clk) disable iff (!nrst) // R11
    !cfgTwo_q[`MCC_TWO_AVG_OFF] |=> averageDepth_q == `MCC_AVG_DEFAULT)
    else $error("averaging depth not 16");
  AST_PIN_MASK: assert property (@(posedge core_clk) disable iff (!nrst) // R3
    cfgOne_q[`MCC_ONE_PIN9_ANA] |=> !pinControlsUpdate_q ##1 !dacPinLoad_q)
    else $error("load pin active while analog selected");
  AST_TMO_RELEASE: assert property (@(posedge core_clk) disable iff (!nrst) // R12
    $rose(sdaRelease_q) |-> $past(cfgTwo_q[`MCC_TWO_TMO_EN], 2))
    else $error("timeout fired while disabled");

endmodule : mcc_regs
`default_nettype wire

// ---- testbench/mcc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.svh"

module mcc_host_model (
  input  wire logic       core_clk,
  output logic      [7:0] regAddr,
  output logic            regWrEn,
  output logic      [7:0] regWrData,
  output logic            regRdEn
);
  // idle bus after power-up
  initial begin
    regAddr = 8'h00;
    regWrEn = 1'h0;
    regWrData = 8'h00;
    regRdEn = 1'h0;
  end

  // one-cycle strobe launched at the falling edge
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge core_clk);
    regAddr = a;
    regWrData = (a == `MCC_ADDR_CFG_ONE) ? (d & 8'hEF) : d;
    regWrEn = w;
    regRdEn = ~w;
    @(negedge core_clk);
    regWrEn = 1'h0;
    regRdEn = 1'h0;
    regAddr = ~regAddr; // released bus no longer holds old value
    regWrData = ~regWrData;
  endtask : xfer
endmodule : mcc_host_model
`default_nettype wire

// ---- testbench/tb_monitor_control_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.svh"

module tb_monitor_control_config_regs
  import mcc_pkg::*;
;
  localparam int TMO = 50;
  logic core_clk = 1'h0;
  logic nrst = 1'h0;
  logic [7:0] regAddr, regWrData, regRdData_q, d, expQ[$];
  logic regWrEn, regRdEn, intOut_q, monitorRun_q, singleChannel_q, pin9Analog_q;
  logic standby_q, pinControlsUpdate_q, dacPinLoad_q, swResetPulse_q, sdaRelease_q;
  logic alarmEvent = 1'h0, updateSourceBit = 1'h0, dacLoadStrobePin = 1'h1, sclPin = 1'h1;
  logic rdSeen = 1'h0;
  logic [4:0] averageDepth_q;
  logic [2:0] src;
  mcc_mux_type analogMux_q;
  mcc_src_type convSource_q;
  int n_fail = 0, num_checks = 0, nLoad = 0, nSw = 0, cyc = 0, n0 = 0;
  int seed = 32'hD2DA464D;

  always #20 core_clk = ~core_clk;

  mcc_host_model HOST (.core_clk(core_clk), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn));

  mcc_regs #(.TMO_CYCLES(TMO)) DUT (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .alarmEvent(alarmEvent), .updateSourceBit(updateSourceBit), .dacLoadStrobePin(dacLoadStrobePin),
    .sclPin(sclPin), .intOut_q(intOut_q), .monitorRun_q(monitorRun_q),
    .singleChannel_q(singleChannel_q), .analogMux_q(analogMux_q), .pin9Analog_q(pin9Analog_q),
    .convSource_q(convSource_q), .averageDepth_q(averageDepth_q), .standby_q(standby_q),
    .pinControlsUpdate_q(pinControlsUpdate_q), .dacPinLoad_q(dacPinLoad_q),
    .swResetPulse_q(swResetPulse_q), .sdaRelease_q(sdaRelease_q));

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkBit(input logic got, input logic exp);
    chk({7'h00, got}, {7'h00, exp});
  endtask : chkBit

  // write, then let register and mode outputs settle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    HOST.xfer(a, v, 1'h1);
    repeat (2) @(negedge core_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    HOST.xfer(a, 8'h00, 1'h0);
  endtask : rd

  // pulse counters, watchdog and read-data watcher
  always @(posedge core_clk) begin
    rdSeen <= regRdEn;
    cyc <= cyc + 1;
    if (dacPinLoad_q === 1'h1) nLoad <= nLoad + 1;
    if (swResetPulse_q === 1'h1) nSw <= nSw + 1;
    if (cyc > 6000) begin
      n_fail++;
      summarize();
    end
  end

  always @(negedge core_clk) if (rdSeen) chk(regRdData_q, expQ.pop_front());

  // main sequence
  initial begin
    repeat (16) @(negedge core_clk);
    nrst = 1'h1;
    @(negedge core_clk);
    rd(`MCC_ADDR_CFG_ONE, 8'h00);
    rd(`MCC_ADDR_CFG_TWO, 8'h00);
    chk({1'h0, monitorRun_q, singleChannel_q, analogMux_q, pin9Analog_q, standby_q, intOut_q}, 8'h01);
    chk({3'h0, averageDepth_q}, 8'h10);
    chk({5'h0, convSource_q}, 8'h00);
    // random round trips, standby keeps register access alive
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      wr(`MCC_ADDR_CFG_ONE, d);
      rd(`MCC_ADDR_CFG_ONE, d & 8'hEF);
      wr(`MCC_ADDR_CFG_TWO, d & 8'h7F);
      rd(`MCC_ADDR_CFG_TWO, d & 8'h7F);
      chkBit(monitorRun_q, d[0] & ~d[7]);
      chkBit(standby_q, d[7]);
      chkBit(singleChannel_q, d[4]);
    end
    wr(8'h20, 8'hFF);
    rd(8'h20, `MCC_RD_UNMAPPED);
    // every channel code under both mux settings
    for (int m = 0; m < 2; m++) begin
      wr(`MCC_ADDR_CFG_ONE, {5'h00, m[0], 2'h0});
      chk({6'h00, analogMux_q}, {6'h00, m[0], 1'h0});
      for (int c = 0; c < 8; c++) begin
        wr(`MCC_ADDR_CFG_TWO, {2'h0, c[0], 2'h2, c[2:0]});
        src = (c == 2) ? (m[0] ? MCC_SRC_EXT_TEMP : MCC_SRC_AIN_ONE)
            : (c > 5) ? MCC_SRC_NONE : (c < 2) ? 3'(c) : 3'(c + 1);
        chk({5'h00, convSource_q}, {5'h00, src});
        chk({3'h0, averageDepth_q}, c[0] ? 8'h01 : 8'h10);
      end
    end
    // interrupt enable, polarity, pin function and load strobe
    for (int k = 0; k < 16; k++) begin
      alarmEvent = k[0];
      updateSourceBit = k[0];
      wr(`MCC_ADDR_CFG_ONE, {1'h0, k[2], k[1], 1'h0, k[3], 3'h0});
      chkBit(intOut_q, (k[0] & ~k[1]) ? k[2] : ~k[2]);
      chkBit(pin9Analog_q, k[3]);
      chkBit(pinControlsUpdate_q, ~k[3] & ~k[0]);
      n0 = nLoad;
      dacLoadStrobePin = 1'h0;
      repeat (8) @(negedge core_clk);
      dacLoadStrobePin = 1'h1;
      repeat (2) @(negedge core_clk);
      chk(8'(nLoad - n0), {7'h00, ~k[3] & ~k[0]});
    end
    alarmEvent = 1'h0;
    // serial clock stuck low, timeout off then on
    for (int e = 0; e < 2; e++) begin
      wr(`MCC_ADDR_CFG_TWO, {1'h0, e[0], 6'h00});
      sclPin = 1'h0;
      repeat (TMO - 10) @(negedge core_clk);
      chkBit(sdaRelease_q, 1'h0);
      repeat (20) @(negedge core_clk);
      chkBit(sdaRelease_q, e[0]);
      sclPin = 1'h1;
      repeat (8) @(negedge core_clk);
      chkBit(sdaRelease_q, 1'h0);
    end
    // standby with monitoring requested still stops conversions
    wr(`MCC_ADDR_CFG_ONE, 8'h81);
    chkBit(standby_q, 1'h1);
    chkBit(monitorRun_q, 1'h0);
    // software reset clears both registers
    wr(`MCC_ADDR_CFG_ONE, 8'hC9);
    n0 = nSw;
    wr(`MCC_ADDR_CFG_TWO, 8'hB5);
    @(negedge core_clk);
    chk(8'(nSw - n0), 8'h01);
    rd(`MCC_ADDR_CFG_ONE, `MCC_CFG_RESET);
    rd(`MCC_ADDR_CFG_TWO, `MCC_CFG_RESET);
    chk({3'h0, averageDepth_q}, 8'h10);
    chkBit(intOut_q, 1'h1);
    @(negedge core_clk);
    summarize();
  end
endmodule : tb_monitor_control_config_regs
`default_nettype wire
